/* File: src/tbcp_pkg.sv */
// Behaviour
// - emulation 00: halt right after next count
// - emulation 01, up mode: halt at period
// - emulation 01, down/updown: halt at zero
// - emulation 1x: ignore debug halt, free run
// - phase direction used only in up-down mode
// - after phase load in up-down mode, direction follows phase_direction
// - coarse prescale divides by two to field power
// - coarse prescale resets to 000
// - tick period is highspeed times coarse divisor
// - highspeed prescale at bits 9:7, reset 001
// - highspeed 000 is /1, else twice field
// - software sync write pulses once, reads zero
// - period_load_direct selects shadowed or direct period
// - phase_load_enable gates sync-driven phase loads
package tbcp_pkg;
  localparam logic [11:0] TBCP_ADDR_CONTROL = 12'h000;
  localparam logic [11:0] TBCP_ADDR_PERIOD  = 12'h004;
  localparam logic [11:0] TBCP_ADDR_PHASE   = 12'h008;
  localparam logic [11:0] TBCP_ADDR_COUNTER = 12'h00c;
  localparam logic [11:0] TBCP_ADDR_STATUS  = 12'h010;
  localparam logic [11:0] TBCP_ADDR_DEBUG   = 12'h014;

  localparam int TBCP_EMU_HI      = 15;
  localparam int TBCP_EMU_LO      = 14;
  localparam int TBCP_PHASE_DIRECTION_BIT  = 13;
  localparam int TBCP_COARSE_HI   = 12;
  localparam int TBCP_COARSE_LO   = 10;
  localparam int TBCP_HS_HI       = 9;
  localparam int TBCP_HS_LO       = 7;
  localparam int TBCP_SWSYNC_BIT  = 6;
  localparam int TBCP_SYNCSEL_HI  = 5;
  localparam int TBCP_SYNCSEL_LO  = 4;
  localparam int TBCP_PERIOD_LOAD_DIRECT_BIT   = 3;
  localparam int TBCP_PHASE_LOAD_ENABLE_BIT   = 2;
  localparam int TBCP_MODE_HI     = 1;
  localparam int TBCP_MODE_LO     = 0;

  localparam logic [15:0] TBCP_CONTROL_RESET = 16'h0083;
  localparam logic [15:0] TBCP_PERIOD_RESET  = 16'h0000;
  localparam logic [15:0] TBCP_PHASE_RESET   = 16'h0000;
  localparam logic [15:0] TBCP_COUNT_ZERO    = 16'h0000;
  localparam logic [10:0] TBCP_DIV_ONE       = 11'h001;

  typedef enum logic [1:0] {
    TBCP_MODE_UP     = 2'b00,
    TBCP_MODE_DOWN   = 2'b01,
    TBCP_MODE_UPDOWN = 2'b10,
    TBCP_MODE_STOP   = 2'b11
  } tbcp_mode_t;

  typedef enum logic [1:0] {
    TBCP_EMU_NEXT  = 2'b00,
    TBCP_EMU_CYCLE = 2'b01,
    TBCP_EMU_FREE0 = 2'b10,
    TBCP_EMU_FREE1 = 2'b11
  } tbcp_emu_t;

  typedef enum logic [1:0] {
    TBCP_RUN     = 2'b00,
    TBCP_STOPPING = 2'b01,
    TBCP_HALTED  = 2'b10
  } tbcp_halt_t;
endpackage : tbcp_pkg

/* File: src/tbcp_prescaler.sv */
`timescale 1ns/10ps
module tbcp_prescaler
  import tbcp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] coarse_prescale,
  input  wire logic [2:0] highspeed_prescale,
  output logic            time_base_tick
);
  logic [3:0]  hs_cnt_q;
  logic [3:0]  hs_cnt_d;
  logic [7:0]  cs_cnt_q;
  logic [7:0]  cs_cnt_d;
  logic [3:0]  hs_div;
  logic [7:0]  cs_div;
  logic        hs_wrap;
  logic        tick_d;
  logic        tick_q;

  always_comb begin
    // high-speed stage: 000 is /1, else twice the field
    hs_div = (highspeed_prescale == 3'h0) ? 4'h1 : {highspeed_prescale, 1'b0};
    cs_div = 8'h01 << coarse_prescale;
    hs_wrap = (hs_cnt_q >= hs_div - 4'h1);
    hs_cnt_d = hs_wrap ? 4'h0 : hs_cnt_q + 4'h1;
    cs_cnt_d = cs_cnt_q;
    tick_d = 1'b0;
    // coarse stage counts high-speed wraps, so tick period is the product
    if (hs_wrap) begin
      if (cs_cnt_q >= cs_div - 8'h01) begin
        cs_cnt_d = 8'h00;
        tick_d = 1'b1;
      end else begin
        cs_cnt_d = cs_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hs_cnt_q <= 4'h0;
      cs_cnt_q <= 8'h00;
      tick_q   <= 1'b0;
    end else begin
      hs_cnt_q <= hs_cnt_d;
      cs_cnt_q <= cs_cnt_d;
      tick_q   <= tick_d;
    end
  end

  assign time_base_tick = tick_q;
endmodule : tbcp_prescaler

/* File: src/tbcp_time_base.sv */
`timescale 1ns/10ps
module tbcp_time_base
  import tbcp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        debug_halt,
  input  wire logic        sync_input,
  output logic             sync_event,
  output logic             time_base_tick,
  output logic      [15:0] time_base_counter,
  output logic             counting_up,
  output logic             counter_halted,
  output logic      [1:0]  sync_output_select
);
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] prd_act_q;
  logic [15:0] prd_act_d;
  logic [15:0] prd_shd_q;
  logic [15:0] prd_shd_d;
  logic [15:0] phase_q;
  logic [15:0] phase_d;
  logic [15:0] ctr_q;
  logic [15:0] ctr_d;
  logic        up_q;
  logic        up_d;
  logic        swsync_q;
  logic        swsync_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  tbcp_halt_t  halt_q;
  tbcp_halt_t  halt_d;
  logic        tick;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic        sync_any;
  logic        step;
  logic        freeze_now;
  logic        at_zero;
  logic        at_period;
  tbcp_mode_t  mode;
  tbcp_emu_t   emu;

  tbcp_prescaler u_prescaler (
    .core_clk           (core_clk),
    .resetn             (resetn),
    .coarse_prescale    (ctrl_q[TBCP_COARSE_HI:TBCP_COARSE_LO]),
    .highspeed_prescale (ctrl_q[TBCP_HS_HI:TBCP_HS_LO]),
    .time_base_tick     (tick)
  );

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  assign acc       = psel & penable;
  assign wr        = acc & pwrite;
  assign mapped    = addr_is(paddr, TBCP_ADDR_CONTROL) | addr_is(paddr, TBCP_ADDR_PERIOD) |
                     addr_is(paddr, TBCP_ADDR_PHASE) | addr_is(paddr, TBCP_ADDR_COUNTER) |
                     addr_is(paddr, TBCP_ADDR_STATUS) | addr_is(paddr, TBCP_ADDR_DEBUG);
  assign pready    = 1'b1;
  assign pslverr   = acc & ~mapped;
  assign prdata    = rdata_q;
  assign mode      = tbcp_mode_t'(ctrl_q[TBCP_MODE_HI:TBCP_MODE_LO]);
  assign emu       = tbcp_emu_t'(ctrl_q[TBCP_EMU_HI:TBCP_EMU_LO]);
  assign at_zero   = (ctr_q == TBCP_COUNT_ZERO);
  assign at_period = (ctr_q == prd_act_q);
  assign sync_any  = sync_input | swsync_q;
  // whole-cycle stop must hold the counter at its end point, so no step there
  assign freeze_now = (halt_q == TBCP_STOPPING) & debug_halt & (emu == TBCP_EMU_CYCLE) &
                      ((mode == TBCP_MODE_UP) ? at_period : at_zero);
  assign step      = tick & (mode != TBCP_MODE_STOP) & (halt_q != TBCP_HALTED) & ~freeze_now;

  // register writes and read data
  always_comb begin
    ctrl_d    = ctrl_q;
    prd_shd_d = prd_shd_q;
    phase_d   = phase_q;
    swsync_d  = 1'b0;
    rdata_d   = 32'h0000_0000;
    if (wr && addr_is(paddr, TBCP_ADDR_CONTROL)) begin
      ctrl_d = pwdata[15:0];
      ctrl_d[TBCP_SWSYNC_BIT] = 1'b0;
      swsync_d = pwdata[TBCP_SWSYNC_BIT];
    end
    if (wr && addr_is(paddr, TBCP_ADDR_PERIOD)) begin
      prd_shd_d = pwdata[15:0];
    end
    if (wr && addr_is(paddr, TBCP_ADDR_PHASE)) begin
      phase_d = pwdata[15:0];
    end
    if (acc && !pwrite) begin
      if (addr_is(paddr, TBCP_ADDR_CONTROL)) begin
        rdata_d = {16'h0000, ctrl_q};
      end else if (addr_is(paddr, TBCP_ADDR_PERIOD)) begin
        rdata_d = {16'h0000, prd_act_q};
      end else if (addr_is(paddr, TBCP_ADDR_PHASE)) begin
        rdata_d = {16'h0000, phase_q};
      end else if (addr_is(paddr, TBCP_ADDR_COUNTER)) begin
        rdata_d = {16'h0000, ctr_q};
      end else if (addr_is(paddr, TBCP_ADDR_STATUS)) begin
        rdata_d = {29'h0000_0000, halt_q == TBCP_HALTED, up_q, at_zero};
      end else if (addr_is(paddr, TBCP_ADDR_DEBUG)) begin
        rdata_d = {16'h0000, prd_shd_q};
      end
    end
  end

  // counter, direction, period load
  always_comb begin
    ctr_d     = ctr_q;
    up_d      = up_q;
    prd_act_d = prd_act_q;
    if (wr && addr_is(paddr, TBCP_ADDR_PERIOD) && ctrl_q[TBCP_PERIOD_LOAD_DIRECT_BIT]) begin
      prd_act_d = pwdata[15:0];
    end else if (!ctrl_q[TBCP_PERIOD_LOAD_DIRECT_BIT] && at_zero && step) begin
      prd_act_d = prd_shd_q;
    end
    if (sync_any && ctrl_q[TBCP_PHASE_LOAD_ENABLE_BIT]) begin
      ctr_d = phase_q;
      if (mode == TBCP_MODE_UPDOWN) begin
        up_d = ctrl_q[TBCP_PHASE_DIRECTION_BIT];
      end else if (mode == TBCP_MODE_UP) begin
        up_d = 1'b1;
      end else if (mode == TBCP_MODE_DOWN) begin
        up_d = 1'b0;
      end
    end else if (wr && addr_is(paddr, TBCP_ADDR_COUNTER)) begin
      ctr_d = pwdata[15:0];
    end else if (step) begin
      case (mode)
        TBCP_MODE_UP: begin
          up_d  = 1'b1;
          ctr_d = at_period ? TBCP_COUNT_ZERO : ctr_q + 16'h0001;
        end
        TBCP_MODE_DOWN: begin
          up_d  = 1'b0;
          ctr_d = at_zero ? prd_act_q : ctr_q - 16'h0001;
        end
        TBCP_MODE_UPDOWN: begin
          if (up_q && at_period) begin
            up_d  = 1'b0;
            ctr_d = ctr_q - 16'h0001;
          end else if (!up_q && at_zero) begin
            up_d  = 1'b1;
            ctr_d = ctr_q + 16'h0001;
          end else begin
            ctr_d = up_q ? ctr_q + 16'h0001 : ctr_q - 16'h0001;
          end
        end
        default: begin
          ctr_d = ctr_q;
        end
      endcase
    end
  end

  // debug halt control
  always_comb begin
    halt_d = halt_q;
    case (halt_q)
      TBCP_RUN: begin
        if (debug_halt && !emu[1]) begin
          halt_d = TBCP_STOPPING;
        end
      end
      TBCP_STOPPING: begin
        if (!debug_halt || emu[1]) begin
          halt_d = TBCP_RUN;
        end else if (emu == TBCP_EMU_NEXT) begin
          if (step) begin
            halt_d = TBCP_HALTED;
          end
        end else if (mode == TBCP_MODE_UP) begin
          if (at_period) begin
            halt_d = TBCP_HALTED;
          end
        end else if (at_zero) begin
          halt_d = TBCP_HALTED;
        end
      end
      TBCP_HALTED: begin
        if (!debug_halt || emu[1]) begin
          halt_d = TBCP_RUN;
        end
      end
      default: begin
        halt_d = TBCP_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= TBCP_CONTROL_RESET;
      prd_act_q <= TBCP_PERIOD_RESET;
      prd_shd_q <= TBCP_PERIOD_RESET;
      phase_q   <= TBCP_PHASE_RESET;
      ctr_q     <= TBCP_COUNT_ZERO;
      up_q      <= 1'b1;
      swsync_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      halt_q    <= TBCP_RUN;
    end else begin
      ctrl_q    <= ctrl_d;
      prd_act_q <= prd_act_d;
      prd_shd_q <= prd_shd_d;
      phase_q   <= phase_d;
      ctr_q     <= ctr_d;
      up_q      <= up_d;
      swsync_q  <= swsync_d;
      rdata_q   <= rdata_d;
      halt_q    <= halt_d;
    end
  end

  assign sync_event         = sync_any;
  assign time_base_tick     = tick;
  assign time_base_counter  = ctr_q;
  assign counting_up        = up_q;
  assign counter_halted     = (halt_q == TBCP_HALTED);
  assign sync_output_select = ctrl_q[TBCP_SYNCSEL_HI:TBCP_SYNCSEL_LO];
endmodule : tbcp_time_base

/* File: testbench/tbcp_time_base_asserts.sv */
`timescale 1ns/10ps
module tbcp_time_base_asserts
  import tbcp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        debug_halt,
  input wire logic        sync_input,
  input wire logic        sync_event,
  input wire logic        time_base_tick,
  input wire logic [15:0] time_base_counter,
  input wire logic        counting_up,
  input wire logic        counter_halted
);
  logic [15:0] ctl_q, ctl_d, prd_q, prd_d, phs_q, phs_d;
  logic [11:0] gap_q, gap_d, dv;
  logic        ok_q, ok_d, wr;
  assign wr = psel && penable && pwrite;
  assign dv = ((ctl_q[9:7] == 3'h0) ? 12'h001 : {8'h00, ctl_q[9:7], 1'b0}) << ctl_q[12:10];
  always_comb begin
    ctl_d = (wr && paddr == TBCP_ADDR_CONTROL) ? pwdata[15:0] : ctl_q;
    prd_d = (wr && paddr == TBCP_ADDR_PERIOD) ? pwdata[15:0] : prd_q;
    phs_d = (wr && paddr == TBCP_ADDR_PHASE) ? pwdata[15:0] : phs_q;
    gap_d = time_base_tick ? 12'h000 : gap_q + 12'h001;
    // interval is trusted only between two ticks after the last control write
    ok_d  = (ok_q || time_base_tick) && !(wr && paddr == TBCP_ADDR_CONTROL);
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= TBCP_CONTROL_RESET;
      prd_q <= TBCP_PERIOD_RESET;
      phs_q <= TBCP_PHASE_RESET;
      gap_q <= 12'h000;
      ok_q  <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      prd_q <= prd_d;
      phs_q <= phs_d;
      gap_q <= gap_d;
      ok_q  <= ok_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_load;
    sync_event && ctl_q[2];
  endsequence
  sequence s_cycle_halt;
    $rose(counter_halted) && ctl_q[15:14] == 2'b01;
  endsequence
  a_tick_period: assert property (time_base_tick && ok_q |-> gap_q == dv - 12'h001)
    else $error("tick spacing off");
  a_sync_or: assert property (sync_input |-> sync_event)
    else $error("external sync lost");
  a_sw_pulse: assert property (wr && paddr == TBCP_ADDR_CONTROL && pwdata[6] |=> sync_event ##1 !sync_event)
    else $error("software sync not one pulse");
  a_phase_load: assert property (s_load |=> time_base_counter == phs_q)
    else $error("phase not loaded");
  a_sync_ignored: assert property (sync_event && !ctl_q[2] && ctl_q[1:0] == 2'b11 && !wr |=> $stable(time_base_counter))
    else $error("sync not ignored");
  a_phase_dir: assert property (s_load and (ctl_q[1:0] == 2'b10) |=> counting_up == ctl_q[13])
    else $error("direction after load wrong");
  a_dir_fixed: assert property (s_load and (!ctl_q[1]) |=> counting_up == !ctl_q[0])
    else $error("direction bit not ignored");
  a_free_run: assert property (ctl_q[15] && $past(ctl_q[15]) |-> !counter_halted)
    else $error("halted in free run");
  a_halt_freeze: assert property (counter_halted && $past(counter_halted) && !$past(sync_event) && !$past(wr)
    |-> $stable(time_base_counter))
    else $error("halted counter moved");
  a_halt_period: assert property (s_cycle_halt and ctl_q[1:0] == 2'b00 |-> time_base_counter == prd_q)
    else $error("up halt not at period");
  a_halt_zero: assert property (s_cycle_halt and (ctl_q[0] ^ ctl_q[1]) |-> time_base_counter == 16'h0000)
    else $error("halt not at zero");
  a_halt_soon: assert property (debug_halt && $past(debug_halt) && ctl_q[15:14] == 2'b00 && ctl_q[1:0] != 2'b11
    && time_base_tick |-> ##[1:3] counter_halted)
    else $error("no halt after step");
endmodule : tbcp_time_base_asserts

/* File: testbench/time_base_control_prescale_test.sv */
`timescale 1ns/10ps
module time_base_control_prescale_test;
  import tbcp_pkg::*;
  logic        core_clk, resetn, psel, penable, pwrite, debug_halt, sync_input, err;
  logic        pready, pslverr, sync_event, time_base_tick, counting_up, counter_halted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] time_base_counter, c0, w, ph;
  logic [1:0]  sync_output_select, m, e;
  logic [2:0]  c, h;
  logic [31:0] seed = 32'h1268;
  int          failures = 0;
  int          checks = 0;
  int          g;
  tbcp_time_base DUT (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] ctl(logic [1:0] em, logic d, logic [2:0] cd, logic [2:0] hd, logic [6:0] lo);
    return {em, d, cd, hd, lo};
  endfunction : ctl
  function automatic int divof(logic [2:0] cd, logic [2:0] hd);
    return (hd == 3'h0 ? 1 : 2 * hd) << cd;
  endfunction : divof
  task automatic tally_and_finish();
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic await(ref logic s, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask : await
  task automatic apb(input logic wn, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wn;
    paddr   <= a;
    pwdata  <= {seed[31:16], d};
    @(posedge core_clk);
    penable <= 1'b1;
    await(pready, 50);
    err = pslverr;
    @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
    rd = prdata;
  endtask : apb
  initial begin
    {resetn, psel, penable, pwrite, debug_halt, sync_input} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, TBCP_ADDR_CONTROL, 16'h0000);
    chk(rd, {16'h0000, ctl(2'b00, 1'b0, 3'h0, 3'h1, 7'h03)});
    apb(1'b0, 12'h020, 16'h0000);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 6; i++) begin
      c = (i < 2) ? 3'(i * 7) : 3'(rnd());
      h = (i < 2) ? 3'(i * 7) : 3'(rnd());
      apb(1'b1, TBCP_ADDR_CONTROL, ctl(2'b10, 1'b0, c, h, 7'h03));
      await(time_base_tick, 2000);
      g = 0;
      do begin
        @(negedge core_clk);
        g++;
      end while (time_base_tick !== 1'b1 && g < 2000);
      chk(g, divof(c, h));
    end
    apb(1'b1, TBCP_ADDR_CONTROL, ctl(2'b10, 1'b0, 3'h7, 3'h7, 7'h0b));
    apb(1'b1, TBCP_ADDR_PERIOD, 16'h0100);
    apb(1'b1, TBCP_ADDR_PHASE, 16'h0040);
    for (int i = 0; i < 6; i++) begin
      m = 2'(i / 2);
      w = ctl(2'b10, i[0], 3'h7, 3'h7, {5'b10011, m});
      apb(1'b1, TBCP_ADDR_CONTROL, w);
      @(negedge core_clk);
      chk(counting_up, m == 2'b00 ? 1'b1 : m == 2'b01 ? 1'b0 : i[0]);
      apb(1'b0, TBCP_ADDR_CONTROL, 16'h0000);
      chk(rd, {16'h0000, w & 16'hffbf});
    end
    for (int i = 0; i < 2; i++) begin
      ph = 16'(rnd());
      apb(1'b1, TBCP_ADDR_CONTROL, ctl(2'b10, 1'b0, 3'h0, 3'h0, {4'h0, ~i[0], 2'b11}));
      apb(1'b1, TBCP_ADDR_PHASE, ph);
      c0 = time_base_counter;
      @(posedge core_clk);
      sync_input <= 1'b1;
      @(posedge core_clk);
      sync_input <= 1'b0;
      @(negedge core_clk);
      chk(time_base_counter, i == 0 ? ph : c0);
    end
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 2'b00 : 2'b01;
      m = (i < 2) ? 2'b00 : 2'(i - 1);
      apb(1'b1, TBCP_ADDR_CONTROL, ctl(e, 1'b0, 3'h0, 3'h0, {5'b00010, m}));
      apb(1'b1, TBCP_ADDR_PERIOD, 16'h0020);
      apb(1'b1, TBCP_ADDR_COUNTER, 16'h0010);
      @(posedge core_clk);
      debug_halt <= 1'b1;
      await(counter_halted, 200);
      c0 = time_base_counter;
      repeat (5) @(negedge core_clk);
      chk(time_base_counter, c0);
      if (i > 0) chk(c0, m == 2'b00 ? 16'h0020 : 16'h0000);
      @(posedge core_clk);
      debug_halt <= 1'b0;
    end
    apb(1'b1, TBCP_ADDR_CONTROL, ctl(2'b10, 1'b0, 3'h0, 3'h0, 7'h08));
    @(posedge core_clk);
    debug_halt <= 1'b1;
    c0 = time_base_counter;
    repeat (10) @(negedge core_clk);
    chk(counter_halted, 1'b0);
    chk(time_base_counter == c0, 1'b0);
    @(posedge core_clk);
    debug_halt <= 1'b0;
    apb(1'b1, TBCP_ADDR_CONTROL, ctl(2'b10, 1'b0, 3'h0, 3'h0, 7'h03));
    apb(1'b1, TBCP_ADDR_PERIOD, 16'h0030);
    apb(1'b0, TBCP_ADDR_PERIOD, 16'h0000);
    chk(rd, 32'h20);
    apb(1'b1, TBCP_ADDR_CONTROL, ctl(2'b10, 1'b0, 3'h0, 3'h0, 7'h00));
    repeat (80) @(posedge core_clk);
    apb(1'b0, TBCP_ADDR_PERIOD, 16'h0000);
    chk(rd, 32'h30);
    tally_and_finish();
  end
endmodule : time_base_control_prescale_test
bind tbcp_time_base tbcp_time_base_asserts chk (.*);
